/* hdl/isoirq_pkg.sv */
package isoirq_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] TX_MASK_SET_OFS   = 8'h98;
    localparam logic [7:0] TX_MASK_CLR_OFS   = 8'h9c;
    localparam logic [7:0] RX_EVENT_SET_OFS  = 8'ha0;
    localparam logic [7:0] RX_EVENT_CLR_OFS  = 8'ha4;
    localparam logic [7:0] RX_MASK_SET_OFS   = 8'ha8;
    localparam logic [7:0] RX_MASK_CLR_OFS   = 8'hac;
    localparam logic [7:0] INIT_BW_OFS       = 8'hb0;
    localparam logic [7:0] TX_EVENT_VIEW_OFS = 8'hc0;
    localparam logic [7:0] IRQ_STATUS_OFS    = 8'hc4;
    localparam logic [7:0] IRQ_MASK_OFS      = 8'hc8;
    localparam logic [7:0] CTRL_OFS          = 8'hcc;

    // ------------------------------------------------------------
    // Field widths and reset values
    // ------------------------------------------------------------
    localparam int         TX_CTX_N      = 8;
    localparam int         RX_CH_N       = 4;
    localparam int         BW_W          = 13;
    localparam int         IRQ_W         = 3;
    localparam logic [12:0] BW_RESET     = 13'h1333;
    localparam logic [7:0] TX_MASK_RESET = 8'h00;
    localparam logic [3:0] RX_MASK_RESET = 4'h0;
    localparam logic [3:0] RX_EVT_RESET  = 4'h0;
    localparam int         IRQ_TX_BIT    = 0;
    localparam int         IRQ_RX_BIT    = 1;
    localparam int         IRQ_LOAD_BIT  = 2;
    localparam int         CTRL_SWRST_BIT = 0;

    // ------------------------------------------------------------
    // Bus request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } isoirq_req_t;

endpackage

/* hdl/isoirq_regs.sv */
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module isoirq_regs
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic      [1:0]  avs_response_o,
    input  wire logic [7:0]  tx_event_i,
    input  wire logic        rx_cmd_done_i,
    input  wire logic [1:0]  rx_cmd_ctx_i,
    input  wire logic        rx_cmd_irq_i,
    input  wire logic        global_reset_pin_i,
    input  wire logic        fundamental_reset_i,
    input  wire logic        power_reset_pin_i,
    input  wire logic        bus_reset_i,
    output logic             iso_transmit_summary_irq_o,
    output logic             iso_receive_summary_irq_o,
    output logic      [12:0] bw_csr_o,
    output logic             bw_csr_load_o,
    output logic             irq_o
);

    // ------------------------------------------------------------
    // Reset synchroniser and input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic [3:0] pin_prev_reg;
    logic       swrst_reg;
    logic       srst_n;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n  = rst_sync_reg[1];
    assign srst_n = ~swrst_reg;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_reg   <= 4'h0;
            pin_s2_reg   <= 4'h0;
            pin_prev_reg <= 4'h0;
        end
        else
        begin
            pin_s1_reg   <= {global_reset_pin_i, fundamental_reset_i,
                             power_reset_pin_i, bus_reset_i};
            pin_s2_reg   <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
        end
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    isoirq_pkg::isoirq_req_t req;
    logic        acc;
    logic        wr_en;
    logic [31:0] wmask;
    logic        hit_txs;
    logic        hit_txc;
    logic        hit_rxes;
    logic        hit_rxec;
    logic        hit_rxms;
    logic        hit_rxmc;
    logic        hit_bw;
    logic        hit_txv;
    logic        hit_ists;
    logic        hit_imsk;
    logic        hit_ctrl;
    logic        hit_any;
    logic [31:0] bmask;
    logic        ack_reg;

    assign req = '{rd:    avs_read_i,
                   wr:    avs_write_i,
                   addr:  avs_address_i,
                   wdata: avs_writedata_i,
                   be:    avs_byteenable_i};

    function automatic logic [31:0] be_expand(input logic [3:0] be);
        be_expand = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    assign acc      = (req.rd | req.wr) & ~ack_reg;
    // Writes commit at the edge where the master sees waitrequest low
    assign wr_en    = ack_reg & req.wr;
    assign bmask    = be_expand(req.be);
    assign wmask    = req.wdata & bmask;
    assign hit_txs  = req.addr == isoirq_pkg::TX_MASK_SET_OFS;
    assign hit_txc  = req.addr == isoirq_pkg::TX_MASK_CLR_OFS;
    assign hit_rxes = req.addr == isoirq_pkg::RX_EVENT_SET_OFS;
    assign hit_rxec = req.addr == isoirq_pkg::RX_EVENT_CLR_OFS;
    assign hit_rxms = req.addr == isoirq_pkg::RX_MASK_SET_OFS;
    assign hit_rxmc = req.addr == isoirq_pkg::RX_MASK_CLR_OFS;
    assign hit_bw   = req.addr == isoirq_pkg::INIT_BW_OFS;
    assign hit_txv  = req.addr == isoirq_pkg::TX_EVENT_VIEW_OFS;
    assign hit_ists = req.addr == isoirq_pkg::IRQ_STATUS_OFS;
    assign hit_imsk = req.addr == isoirq_pkg::IRQ_MASK_OFS;
    assign hit_ctrl = req.addr == isoirq_pkg::CTRL_OFS;
    assign hit_any  = hit_txs | hit_txc | hit_rxes | hit_rxec | hit_rxms | hit_rxmc
                    | hit_bw | hit_txv | hit_ists | hit_imsk | hit_ctrl;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  tx_mask_reg;
    logic [7:0]  tx_mask_next;
    logic [3:0]  rx_evt_reg;
    logic [3:0]  rx_evt_next;
    logic [3:0]  rx_mask_reg;
    logic [3:0]  rx_mask_next;
    logic [12:0] bw_reg;
    logic [12:0] bw_next;
    logic [2:0]  ists_reg;
    logic [2:0]  ists_next;
    logic [2:0]  imsk_reg;
    logic [2:0]  imsk_next;
    logic [3:0]  rx_done_prev_reg;
    logic [3:0]  rx_sig;
    logic [3:0]  rx_rise;
    logic        tx_sum;
    logic        rx_sum;
    logic        load_evt;
    logic [2:0]  evt;

    // Per-channel internal interrupt signal from completed input commands
    genvar g;
    generate
        for (g = 0; g < isoirq_pkg::RX_CH_N; g++)
        begin : g_rx
            assign rx_sig[g] = rx_cmd_done_i & rx_cmd_irq_i
                             & (rx_cmd_ctx_i == 2'(g));
        end
    endgenerate
    // Edge detect so a held channel signal sets its event only once
    assign rx_rise = rx_sig & ~rx_done_prev_reg;

    assign tx_mask_next = wr_en & hit_txs ? tx_mask_reg | wmask[7:0]
                        : wr_en & hit_txc ? tx_mask_reg & ~wmask[7:0]
                        : tx_mask_reg;
    assign rx_evt_next  = ((wr_en & hit_rxec) ? rx_evt_reg & ~wmask[3:0] : rx_evt_reg)
                        | rx_rise
                        | ((wr_en & hit_rxes) ? wmask[3:0] : 4'h0);
    assign rx_mask_next = wr_en & hit_rxms ? rx_mask_reg | wmask[3:0]
                        : wr_en & hit_rxmc ? rx_mask_reg & ~wmask[3:0]
                        : rx_mask_reg;
    assign bw_next      = wr_en & hit_bw
                        ? (bw_reg & ~bmask[12:0]) | (req.wdata[12:0] & bmask[12:0])
                        : bw_reg;

    assign tx_sum   = |(tx_event_i & tx_mask_reg);
    assign rx_sum   = |(rx_evt_reg & rx_mask_reg);
    // Each synced reset pin loads the CSR once, on its rising edge
    assign load_evt = |(pin_s2_reg & ~pin_prev_reg);
    assign evt      = {load_evt, rx_sum, tx_sum};
    assign ists_next = (wr_en & hit_ists ? ists_reg & ~wmask[2:0] : ists_reg) | evt;
    assign imsk_next = wr_en & hit_imsk ? wmask[2:0] : imsk_reg;

    // ------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            tx_mask_reg <= isoirq_pkg::TX_MASK_RESET;
        else if (!srst_n)
            tx_mask_reg <= isoirq_pkg::TX_MASK_RESET;
        else
            tx_mask_reg <= tx_mask_next;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rx_mask_reg <= isoirq_pkg::RX_MASK_RESET;
        else if (!srst_n)
            rx_mask_reg <= isoirq_pkg::RX_MASK_RESET;
        else
            rx_mask_reg <= rx_mask_next;
    end

    // ------------------------------------------------------------
    // Receive event register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rx_evt_reg <= isoirq_pkg::RX_EVT_RESET;
        else if (!srst_n)
            rx_evt_reg <= isoirq_pkg::RX_EVT_RESET;
        else
            rx_evt_reg <= rx_evt_next;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rx_done_prev_reg <= 4'h0;
        else if (!srst_n)
            rx_done_prev_reg <= 4'h0;
        else
            rx_done_prev_reg <= rx_sig;
    end

    // ------------------------------------------------------------
    // Initial bandwidth register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            bw_reg <= isoirq_pkg::BW_RESET;
        else if (!srst_n)
            bw_reg <= isoirq_pkg::BW_RESET;
        else
            bw_reg <= bw_next;
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and software reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            ists_reg <= 3'h0;
        else if (!srst_n)
            ists_reg <= 3'h0;
        else
            ists_reg <= ists_next;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            imsk_reg <= 3'h0;
        else if (!srst_n)
            imsk_reg <= 3'h0;
        else
            imsk_reg <= imsk_next;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            swrst_reg <= 1'b0;
        else if (!srst_n)
            swrst_reg <= 1'b0;
        else
            swrst_reg <= wr_en & hit_ctrl & wmask[isoirq_pkg::CTRL_SWRST_BIT];
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] rdata;
    assign rdata = (hit_txs | hit_txc)   ? {24'h0, tx_mask_reg}
                 : (hit_rxes | hit_rxec) ? {28'h0, rx_evt_reg}
                 : (hit_rxms | hit_rxmc) ? {28'h0, rx_mask_reg}
                 : hit_bw                ? {19'h0, bw_reg}
                 : hit_txv               ? {24'h0, tx_event_i}
                 : hit_ists              ? {29'h0, ists_reg}
                 : hit_imsk              ? {29'h0, imsk_reg}
                 : 32'h0;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // One wait state: the answer stands in the cycle after the request is taken
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_reg           <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end
        else
        begin
            ack_reg           <= acc;
            avs_waitrequest_o <= ~acc;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avs_readdata_o <= 32'h0;
            avs_response_o <= 2'h0;
        end
        else
        begin
            avs_readdata_o <= acc & req.rd ? rdata : 32'h0;
            avs_response_o <= acc & ~hit_any ? 2'h2 : 2'h0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            iso_transmit_summary_irq_o <= 1'b0;
            iso_receive_summary_irq_o  <= 1'b0;
        end
        else
        begin
            iso_transmit_summary_irq_o <= tx_sum;
            iso_receive_summary_irq_o  <= rx_sum;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            irq_o <= 1'b0;
        else
            irq_o <= |(ists_next & imsk_next);
    end

    // ------------------------------------------------------------
    // Bandwidth CSR
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            bw_csr_o <= isoirq_pkg::BW_RESET;
        else if (load_evt)
            bw_csr_o <= bw_reg;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            bw_csr_load_o <= 1'b0;
        else
            bw_csr_load_o <= load_evt;
    end

endmodule

/* testbench/isoirq_regs_chk.sv */
`timescale 1ns/1ns
module isoirq_regs_chk
(
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [1:0]  avs_response_o,
    input wire logic [7:0]  tx_event_i,
    input wire logic        bus_reset_i,
    input wire logic        iso_transmit_summary_irq_o,
    input wire logic [12:0] bw_csr_o,
    input wire logic        bw_csr_load_o
);
    // ----
    // Port checks
    // ----
    wire rd_ack = avs_read_i && !avs_waitrequest_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_take; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
    sequence s_done; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
    AST_ACK: assert property (s_take |=> s_done) else $error("bus answer wrong");
    AST_IDLE: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
        else $error("answer without request");
    AST_RDZ: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0)
        else $error("read data outside answer");
    AST_RX_RSVD: assert property (
        rd_ack && avs_address_i inside {8'ha0, 8'ha4} |-> avs_readdata_o[31:4] == 28'h0)
        else $error("rx event upper bits set");
    AST_BW_RSVD: assert property (
        rd_ack && avs_address_i == 8'hb0 |-> avs_readdata_o[31:13] == 19'h0)
        else $error("bandwidth upper bits set");
    AST_TX_SUM: assert property (
        $rose(iso_transmit_summary_irq_o) |-> $past(tx_event_i) != 8'h00)
        else $error("tx summary without event");
    AST_BW_LOAD: assert property ($rose(bus_reset_i) |-> ##[1:6] bw_csr_load_o)
        else $error("no csr load after bus reset");
    AST_BW_CHG: assert property ($changed(bw_csr_o) |-> bw_csr_load_o)
        else $error("csr changed without load");
    AST_RESP: assert property (!avs_waitrequest_o && avs_address_i < 8'h98
        |-> avs_response_o == 2'h2) else $error("unmapped access not refused");
endmodule
bind isoirq_regs isoirq_regs_chk isoirq_regs_chk_inst (.clk_i, .rstn_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
    .tx_event_i, .bus_reset_i, .iso_transmit_summary_irq_o, .bw_csr_o, .bw_csr_load_o);

/* testbench/isoirq_regs_tb.sv */
`timescale 1ns/1ns
module isoirq_regs_tb;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'hf;
    logic [7:0]  tx_event_i = 8'h00;
    logic        rx_cmd_done_i = 1'b0;
    logic [1:0]  rx_cmd_ctx_i = 2'h0;
    logic        rx_cmd_irq_i = 1'b0;
    logic [3:0]  pin_q = 4'h0;
    logic [31:0] avs_readdata_o, q;
    logic [1:0]  avs_response_o, r;
    logic [12:0] bw_csr_o;
    logic        avs_waitrequest_o, iso_transmit_summary_irq_o, iso_receive_summary_irq_o;
    logic        bw_csr_load_o, irq_o;
    int          error_cnt = 0;
    int          check_count = 0;
    // ----
    // Clock, design and bus tasks
    // ----
    always #5 clk_i = ~clk_i;
    isoirq_regs isoirq_regs_inst
    (
        .clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .avs_response_o,
        .tx_event_i, .rx_cmd_done_i, .rx_cmd_ctx_i, .rx_cmd_irq_i,
        .global_reset_pin_i(pin_q[0]), .fundamental_reset_i(pin_q[1]),
        .power_reset_pin_i(pin_q[2]), .bus_reset_i(pin_q[3]),
        .iso_transmit_summary_irq_o, .iso_receive_summary_irq_o, .bw_csr_o,
        .bw_csr_load_o, .irq_o
    );
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_read_i <= !w;
        avs_write_i <= w;
        avs_address_i <= a;
        avs_writedata_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        r = avs_response_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0)
        begin
            error_cnt++;
            test_done();
        end
        cyc(1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic rx_pulse(input logic [1:0] c, input logic i);
        rx_cmd_done_i <= 1'b1;
        rx_cmd_ctx_i <= c;
        rx_cmd_irq_i <= i;
        cyc(1);
        rx_cmd_done_i <= 1'b0;
        cyc(2);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        rd(8'ha8, 32'h0);
        rd(8'hb0, 32'h1333);
        chk(bw_csr_o, 32'h1333);
        rd(8'h10, 32'h0);
        chk(r, 32'h2);
        $display("test reset done");
    endtask
    task automatic t_tx();
        wr(8'h98, 32'hffff_ffff);
        wr(8'h9c, 32'h0f);
        rd(8'h98, 32'hf0);
        rd(8'h9c, 32'hf0);
        tx_event_i <= 8'h0f;
        cyc(3);
        chk(iso_transmit_summary_irq_o, 32'h0);
        tx_event_i <= 8'h80;
        cyc(3);
        chk(iso_transmit_summary_irq_o, 32'h1);
        rd(8'hc0, 32'h80);
        tx_event_i <= 8'h00;
        $display("test tx mask done");
    endtask
    task automatic t_rx();
        rx_pulse(2'h2, 1'b0);
        rd(8'ha0, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            rx_pulse(c[1:0], 1'b1);
            rd(8'ha0, 32'h1 << c);
            wr(8'ha4, 32'h1 << c);
        end
        wr(8'ha0, 32'hffff_fffd);
        rd(8'ha4, 32'hd);
        wr(8'ha4, 32'h0);
        rd(8'ha0, 32'hd);
        wr(8'ha4, 32'h4);
        rd(8'ha0, 32'h9);
        wr(8'ha4, 32'hf);
        $display("test rx event done");
    endtask
    task automatic t_rxmask_irq();
        wr(8'ha8, 32'h5);
        rd(8'hac, 32'h5);
        wr(8'hac, 32'h4);
        rd(8'ha8, 32'h1);
        wr(8'ha0, 32'h2);
        cyc(2);
        chk(iso_receive_summary_irq_o, 32'h0);
        wr(8'ha0, 32'h1);
        cyc(2);
        chk(iso_receive_summary_irq_o, 32'h1);
        rd(8'ha0, 32'h3);
        rd(8'hc4, 32'h3);
        wr(8'hc8, 32'h2);
        cyc(2);
        chk(irq_o, 32'h1);
        wr(8'hc8, 32'h0);
        cyc(2);
        chk(irq_o, 32'h0);
        wr(8'ha4, 32'hf);
        wr(8'hc4, 32'h7);
        wr(8'hc8, 32'h2);
        cyc(2);
        chk(irq_o, 32'h0);
        $display("test rx mask and irq done");
    endtask
    task automatic t_bw();
        int n;
        for (int k = 0; k < 4; k++)
        begin
            wr(8'hb0, 32'hffff_f100 + k);
            rd(8'hb0, 32'h1100 + k);
            pin_q[k] <= 1'b1;
            n = 0;
            while (bw_csr_o !== 13'h1100 + k && n < 10)
            begin
                cyc(1);
                n++;
            end
            chk(bw_csr_o, 32'h1100 + k);
            pin_q[k] <= 1'b0;
            rd(8'hb0, 32'h1100 + k);
        end
        $display("test bandwidth done");
    endtask
    task automatic t_swrst_be();
        avs_byteenable_i <= 4'h1;
        wr(8'hb0, 32'h0000_00aa);
        avs_byteenable_i <= 4'hf;
        rd(8'hb0, 32'h11aa);
        wr(8'ha8, 32'hf);
        wr(8'hcc, 32'h1);
        rd(8'hb0, 32'h1333);
        rd(8'hac, 32'h0);
        rd(8'h98, 32'h0);
        $display("test soft reset done");
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        test_done();
    end
    initial
    begin
        cyc(6);
        rstn_i <= 1'b1;
        cyc(3);
        t_reset();
        t_tx();
        t_rx();
        t_rxmask_irq();
        t_bw();
        t_swrst_be();
        test_done();
    end
endmodule
